//--- hw/mio_ports.sv
// I/O port logic: input port, nibble output, quasi and three-state ports.
//
// Operation
// [RULE1] Nibble output loads only from pointer nibble.
// [RULE2] Latch read returns edge latches, oscillator pin.
// [RULE3] Quasi input needs written one; outside pulls low.
// [RULE4] Quasi lines independently input or output.
// [RULE5] Port A tests single line or group.
// [RULE6] Reduced variant keeps unpinned lines as flags.
// [RULE7] Tri port A drives buffer, no latch.
// [RULE8] Tri port B latch drives when enabled.
// [RULE9] Tri drivers grouped; B only by copy.
// [RULE10] Outside drives valid levels when disabled.
// [RULE11] Enabled one bit pulls itself high.
// [RULE12] Pins never alter buffer unless host bus.
// [RULE13] Port B latch read only via pins.
// [RULE14] Serial register shifts or counts down.
// [RULE15] Counter mode: out bit, clock latch.
// [RULE16] Shift mode: gated data and gated clock.
// [RULE17] Swap copies carry into clock latch.
// [RULE18] Mode switch changes clock pin immediately.
// [RULE19] Serial input readable; shifts in shift mode.
// [RULE20] Counter decrements on serial input fall.
// [RULE21] One shift per cycle; swap every fourth.
`timescale 1ns/1ps
module mio_ports
  import mio_pkg::*;
#(
  parameter int   PORTA_PINS = 4,
  parameter bit   OSC_INPUT  = 1'b1,
  parameter bit   HOST_BUS   = 1'b0
) (
  input  wire logic                      REF_CLK_I,
  input  wire logic                      SYS_RST_I,
  input  wire mio_pkg::mio_cmd_s         CMD_I,
  output mio_pkg::mio_rsp_s              RSP_O,
  input  wire logic [mio_pkg::IN_W-1:0]  IN_PINS_I,
  input  wire logic                      OSC_PIN_I,
  output logic [mio_pkg::NIB_W-1:0]      OUT_NIBBLE_O,
  input  wire logic [mio_pkg::PORTA_W-1:0] PORTA_I,
  output logic [mio_pkg::PORTA_W-1:0]    PORTA_O,
  output logic [mio_pkg::PORTA_W-1:0]    PORTA_OE_O,
  input  wire logic [mio_pkg::AUX_W-1:0] AUX_I,
  output logic [mio_pkg::AUX_W-1:0]      AUX_O,
  output logic [mio_pkg::AUX_W-1:0]      AUX_OE_O,
  input  wire logic [mio_pkg::BYTE_W-1:0] TRIA_I,
  output logic [mio_pkg::BYTE_W-1:0]     TRIA_O,
  output logic [mio_pkg::BYTE_W-1:0]     TRIA_OE_O,
  output logic [mio_pkg::BYTE_W-1:0]     TRIA_PU_O,
  input  wire logic                      HOST_WR_I,
  input  wire logic [mio_pkg::BYTE_W-1:0] TRIB_I,
  output logic [mio_pkg::BYTE_W-1:0]     TRIB_O,
  output logic [mio_pkg::BYTE_W-1:0]     TRIB_OE_O,
  output logic [mio_pkg::BYTE_W-1:0]     TRIB_PU_O,
  input  wire logic                      SER_IN_I,
  output logic                           SER_OUT_O,
  output logic                           SER_CLK_O
);

  import mio_pkg::*;

  typedef struct packed {
    logic [EN_W-1:0]    en;
    logic [NIB_W-1:0]   nib;
    logic [PORTA_W-1:0] pa;
    logic [AUX_W-1:0]   aux;
    logic [BYTE_W-1:0]  q;
    logic [BYTE_W-1:0]  rb;
    logic [SIO_W-1:0]   shift_count_reg;
    logic               clock_pin_latch;
    logic               ph;
    logic               si_d;
    logic [PORTA_W-1:0] pa_oe;
    logic [AUX_W-1:0]   aux_oe;
    logic [BYTE_W-1:0]  ta_oe;
    logic [BYTE_W-1:0]  ta_pu;
    logic [BYTE_W-1:0]  tb_oe;
    logic [BYTE_W-1:0]  tb_pu;
    logic               so;
    logic               sk;
    mio_rsp_s           rsp;
  } mio_st_s;

  mio_st_s            st_r;
  mio_st_s            st_nxt;
  logic [IN_W-1:0]    latch;
  logic               latch_clr;
  logic [PORTA_W-1:0] pa_rd;
  logic               shift_md;
  logic               si_fall;

  assign latch_clr = CMD_I.op == OP_READ_INPUT_LATCHES;

  mio_edge_latch #(
    .W       (IN_W)
  ) u_latch (
    .clk_i   (REF_CLK_I),
    .rst_i   (SYS_RST_I),
    .pins_i  (IN_PINS_I),
    .clr_i   (latch_clr),
    .latch_o (latch)
  );

  // Unpinned lines of port A read back their own latch as flag storage.
  generate
    for (genvar i = 0; i < PORTA_W; i++) begin : g_pa
      if (i < PORTA_PINS) begin : g_pin
        assign pa_rd[i] = PORTA_I[i];
      end else begin : g_flag
        assign pa_rd[i] = st_r.pa[i]; // RULE6
      end
    end
  endgenerate

  assign shift_md = st_r.en[EN_SHIFT_BIT];
  assign si_fall  = st_r.si_d & ~SER_IN_I;

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rsp      = RSP_RST;
    st_nxt.si_d     = SER_IN_I;
    st_nxt.ph       = ~st_r.ph;

    // Serial register shifts every cycle in shift mode, counts on a serial input fall otherwise; a swap in the same cycle wins.
    if (shift_md) begin
      st_nxt.shift_count_reg = {st_r.shift_count_reg[SIO_W-2:0], SER_IN_I}; // RULE14 RULE19 RULE21
    end else if (si_fall) begin
      st_nxt.shift_count_reg = st_r.shift_count_reg - SIO_ONE; // RULE20
    end

    // Outside logic on the pins never writes the buffer, bar host bus.
    if (HOST_BUS && HOST_WR_I) begin
      st_nxt.q = TRIA_I; // RULE12
    end

    case (CMD_I.op)
      OP_OUT_PTR_NIBBLE: begin
        st_nxt.nib = CMD_I.ptr; // RULE1
      end
      OP_OUT_PORT_A_IMM, OP_OUT_MEM_PORT_A: begin
        st_nxt.pa = CMD_I.data[PORTA_W-1:0]; // RULE4
      end
      OP_OUT_MEM_AUX: begin
        st_nxt.aux = CMD_I.data[AUX_W-1:0];
      end
      OP_READ_PORT_A: begin
        st_nxt.rsp.valid = 1'b1;
        st_nxt.rsp.data  = {{(BYTE_W-PORTA_W){1'b0}}, pa_rd};
      end
      OP_READ_AUX_PORT: begin
        st_nxt.rsp.valid = 1'b1;
        st_nxt.rsp.data  = {{(BYTE_W-AUX_W){1'b0}}, AUX_I};
      end
      OP_READ_INPUT_PORT: begin
        st_nxt.rsp.valid = 1'b1;
        st_nxt.rsp.data  = {{(BYTE_W-IN_W){1'b0}}, IN_PINS_I};
      end
      OP_READ_INPUT_LATCHES: begin
        st_nxt.rsp.valid = 1'b1; // RULE2
        st_nxt.rsp.data  = {{(BYTE_W-IN_W-1){1'b0}},
                            OSC_INPUT & OSC_PIN_I, latch};
      end
      OP_COPY_BUFFER, OP_TABLE_LOAD_BUFFER: begin
        st_nxt.q = CMD_I.data; // RULE7
      end
      OP_READ_BUFFER: begin
        st_nxt.rsp.valid = 1'b1; // RULE12
        st_nxt.rsp.data  = st_r.q;
      end
      OP_LOAD_ENABLE_IMM: begin
        st_nxt.en[NIB_W-1:0] = CMD_I.data[NIB_W-1:0]; // RULE9
      end
      OP_COPY_TO_ENABLE: begin
        st_nxt.en = CMD_I.data; // RULE9
      end
      OP_COPY_BUS_B: begin
        st_nxt.rb = CMD_I.data; // RULE8 RULE13
      end
      OP_READ_TRI_A: begin
        st_nxt.rsp.valid = 1'b1;
        st_nxt.rsp.data  = TRIA_I;
      end
      OP_READ_TRI_B: begin
        st_nxt.rsp.valid = 1'b1; // RULE13
        st_nxt.rsp.data  = TRIB_I;
      end
      OP_SWAP_ACC_SHIFT: begin
        st_nxt.rsp.valid = 1'b1;
        st_nxt.rsp.data  = {{(BYTE_W-SIO_W){1'b0}}, st_r.shift_count_reg};
        st_nxt.shift_count_reg       = CMD_I.data[SIO_W-1:0];
        st_nxt.clock_pin_latch       = CMD_I.carry; // RULE17
      end
      OP_READ_SER_IN: begin
        st_nxt.rsp.valid = 1'b1; // RULE19
        st_nxt.rsp.data  = {{(BYTE_W-1){1'b0}}, SER_IN_I};
      end
      OP_TEST_A_BIT: begin
        st_nxt.rsp.valid = 1'b1; // RULE5
        st_nxt.rsp.skip  = ~pa_rd[CMD_I.data[1:0]];
      end
      OP_TEST_A_GROUP: begin
        st_nxt.rsp.valid = 1'b1; // RULE5
        st_nxt.rsp.skip  = pa_rd == '0;
      end
      default: begin
        st_nxt.rsp = RSP_RST;
      end
    endcase

    // A one on a quasi line releases it, so the outside may pull it low.
    st_nxt.pa_oe = ~st_nxt.pa; // RULE3 RULE4
    for (int i = PORTA_PINS; i < PORTA_W; i++) begin
      st_nxt.pa_oe[i] = 1'b0; // RULE6
    end
    st_nxt.aux_oe = ~st_nxt.aux;

    // Ones are held up by a weak pull so a pull-down reads as zero.
    st_nxt.ta_oe = {BYTE_W{st_nxt.en[EN_TRI_A_BIT]}} & ~st_nxt.q;
    st_nxt.ta_pu = {BYTE_W{st_nxt.en[EN_TRI_A_BIT]}} & st_nxt.q; // RULE11
    st_nxt.tb_oe = {BYTE_W{st_nxt.en[EN_TRI_B_BIT]}} & ~st_nxt.rb;
    st_nxt.tb_pu = {BYTE_W{st_nxt.en[EN_TRI_B_BIT]}} & st_nxt.rb; // RULE8

    // Outputs follow the next mode at once, so a switch shows next edge.
    if (st_nxt.en[EN_SHIFT_BIT]) begin
      st_nxt.so = st_nxt.en[EN_SER_OUT_BIT] & st_nxt.shift_count_reg[SIO_W-1]; // RULE16
      st_nxt.sk = st_nxt.clock_pin_latch & st_nxt.ph; // RULE16 RULE18
    end else begin
      st_nxt.so = st_nxt.en[EN_SER_OUT_BIT]; // RULE15
      st_nxt.sk = st_nxt.clock_pin_latch; // RULE15 RULE18
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      st_r <= '{en: EN_RST, nib: NIB_RST, pa: PORTA_RST, aux: AUX_RST,
                q: BYTE_RST, rb: BYTE_RST, shift_count_reg: SIO_RST, clock_pin_latch: 1'b0,
                ph: 1'b0, si_d: 1'b1, pa_oe: '0, aux_oe: '0,
                ta_oe: '0, ta_pu: '0, tb_oe: '0, tb_pu: '0,
                so: 1'b0, sk: 1'b0, rsp: RSP_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RSP_O        = st_r.rsp;
  assign OUT_NIBBLE_O = st_r.nib;
  assign PORTA_O      = st_r.pa;
  assign PORTA_OE_O   = st_r.pa_oe;
  assign AUX_O        = st_r.aux;
  assign AUX_OE_O     = st_r.aux_oe;
  assign TRIA_O       = st_r.q;
  assign TRIA_OE_O    = st_r.ta_oe;
  assign TRIA_PU_O    = st_r.ta_pu;
  assign TRIB_O       = st_r.rb;
  assign TRIB_OE_O    = st_r.tb_oe;
  assign TRIB_PU_O    = st_r.tb_pu;
  assign SER_OUT_O    = st_r.so;
  assign SER_CLK_O    = st_r.sk;

  nib_load_a: assert property ( // RULE1
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op == OP_OUT_PTR_NIBBLE |=> OUT_NIBBLE_O == $past(CMD_I.ptr))
    else $error("Nibble port not loaded from pointer.");

  nib_hold_a: assert property ( // RULE1
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op != OP_OUT_PTR_NIBBLE |=> $stable(OUT_NIBBLE_O))
    else $error("Nibble port changed without its command.");

  latch_read_a: assert property ( // RULE2
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    latch_clr |=> RSP_O.valid && RSP_O.data[IN_W-1:0] == $past(latch))
    else $error("Latch read returned wrong data.");

  quasi_rel_a: assert property ( // RULE3
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op inside {OP_OUT_PORT_A_IMM, OP_OUT_MEM_PORT_A}
      && CMD_I.data[0] |=> !PORTA_OE_O[0] && PORTA_O[0])
    else $error("Quasi line driven after a one was written.");

  aux_rel_a: assert property ( // RULE4
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op == OP_OUT_MEM_AUX
      |=> AUX_OE_O == ~$past(CMD_I.data[AUX_W-1:0]))
    else $error("Aux line drive does not follow written data.");

  group_test_a: assert property ( // RULE5
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op == OP_TEST_A_GROUP |=> RSP_O.skip == ($past(pa_rd) == '0))
    else $error("Group test skip wrong.");

  tri_pull_a: assert property ( // RULE11
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (TRIA_OE_O & TRIA_PU_O) == '0 &&
      (TRIA_OE_O | TRIA_PU_O) == {BYTE_W{st_r.en[EN_TRI_A_BIT]}})
    else $error("Port A drive and pull overlap.");

  tri_b_grp_a: assert property ( // RULE9
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (TRIB_OE_O & TRIB_PU_O) == '0 &&
      (TRIB_OE_O | TRIB_PU_O) == {BYTE_W{st_r.en[EN_TRI_B_BIT]}})
    else $error("Port B drivers not switched as a group.");

  bus_b_hold_a: assert property ( // RULE13
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op != OP_COPY_BUS_B |=> $stable(st_r.rb))
    else $error("Port B latch changed without its copy.");

  grp_en_b_a: assert property ( // RULE9
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op == OP_LOAD_ENABLE_IMM |=> $stable(st_r.en[EN_TRI_B_BIT]))
    else $error("Port B enable moved by immediate load.");

  swap_skl_a: assert property ( // RULE17
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    CMD_I.op == OP_SWAP_ACC_SHIFT |=> st_r.clock_pin_latch == $past(CMD_I.carry)
      && RSP_O.data[SIO_W-1:0] == $past(st_r.shift_count_reg))
    else $error("Swap did not copy carry or serial data.");

  cnt_dec_a: assert property ( // RULE20
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !shift_md && si_fall && CMD_I.op != OP_SWAP_ACC_SHIFT
      |=> st_r.shift_count_reg == $past(st_r.shift_count_reg) - SIO_ONE)
    else $error("Counter missed a low-going pulse.");

  shift_in_a: assert property ( // RULE21
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    shift_md && CMD_I.op != OP_SWAP_ACC_SHIFT
      |=> st_r.shift_count_reg == {$past(st_r.shift_count_reg[SIO_W-2:0]), $past(SER_IN_I)})
    else $error("Shift register did not shift once.");

  // A command in the cycle after the switch may legally stop the clock.
  clk_mode_a: assert property ( // RULE18
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !shift_md && st_r.clock_pin_latch && CMD_I.data[EN_SHIFT_BIT]
      && CMD_I.op inside {OP_LOAD_ENABLE_IMM, OP_COPY_TO_ENABLE}
      |=> ##1 SER_CLK_O != $past(SER_CLK_O)
        || $past(CMD_I.op) != OP_NONE)
    else $error("Clock pin did not toggle on mode switch.");

  clk_high_a: assert property ( // RULE18
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    shift_md && st_r.clock_pin_latch && !CMD_I.data[EN_SHIFT_BIT]
      && CMD_I.op inside {OP_LOAD_ENABLE_IMM, OP_COPY_TO_ENABLE}
      |=> SER_CLK_O)
    else $error("Clock pin not high after switch to counter.");

  ser_out_cnt_a: assert property ( // RULE15
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    !shift_md |-> SER_OUT_O == st_r.en[EN_SER_OUT_BIT])
    else $error("Serial out does not follow its enable bit.");

endmodule

//--- hw/mio_pkg.sv
// Shared constants and carrier types for the microcontroller I/O ports.
package mio_pkg;

  localparam int NIB_W    = 4;
  localparam int BYTE_W   = 8;
  localparam int EN_W     = 8;
  localparam int SIO_W    = 4;
  localparam int PORTA_W  = 4;
  localparam int AUX_W    = 4;
  localparam int IN_W     = 4;

  // Enable register bit positions.
  localparam int EN_SHIFT_BIT   = 0;
  localparam int EN_TRI_A_BIT   = 2;
  localparam int EN_SER_OUT_BIT = 3;
  localparam int EN_TRI_B_BIT   = 6;

  // Reset values and the counter decrement step.
  localparam logic [EN_W-1:0]    EN_RST    = 8'h00;
  localparam logic [NIB_W-1:0]   NIB_RST   = 4'h0;
  localparam logic [PORTA_W-1:0] PORTA_RST = 4'hf;
  localparam logic [AUX_W-1:0]   AUX_RST   = 4'hf;
  localparam logic [BYTE_W-1:0]  BYTE_RST  = 8'h00;
  localparam logic [SIO_W-1:0]   SIO_RST   = 4'h0;
  localparam logic [SIO_W-1:0]   SIO_ONE   = 4'h1;

  typedef enum logic [4:0] {
    OP_NONE,
    OP_OUT_PTR_NIBBLE,
    OP_OUT_PORT_A_IMM,
    OP_OUT_MEM_PORT_A,
    OP_OUT_MEM_AUX,
    OP_READ_PORT_A,
    OP_READ_AUX_PORT,
    OP_READ_INPUT_PORT,
    OP_READ_INPUT_LATCHES,
    OP_COPY_BUFFER,
    OP_TABLE_LOAD_BUFFER,
    OP_READ_BUFFER,
    OP_LOAD_ENABLE_IMM,
    OP_COPY_TO_ENABLE,
    OP_COPY_BUS_B,
    OP_READ_TRI_A,
    OP_READ_TRI_B,
    OP_SWAP_ACC_SHIFT,
    OP_READ_SER_IN,
    OP_TEST_A_BIT,
    OP_TEST_A_GROUP
  } mio_op_e;

  typedef struct packed {
    mio_op_e           op;
    logic [BYTE_W-1:0] data;
    logic [NIB_W-1:0]  ptr;
    logic              carry;
  } mio_cmd_s;

  typedef struct packed {
    logic              valid;
    logic              skip;
    logic [BYTE_W-1:0] data;
  } mio_rsp_s;

  localparam mio_rsp_s RSP_RST = '0;

endpackage

//--- hw/mio_edge_latch.sv
// Bank of falling-edge capture latches on the general input port.
`timescale 1ns/1ps
module mio_edge_latch #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] pins_i,
  input  wire logic         clr_i,
  output logic [W-1:0]      latch_o
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] hit;
  } mio_el_s;

  mio_el_s st_r;
  mio_el_s st_nxt;

  // A falling edge seen in the read cycle survives the clear.
  always_comb begin
    st_nxt.prev = pins_i;
    for (int i = 0; i < W; i++) begin
      st_nxt.hit[i] = (st_r.prev[i] & ~pins_i[i]) |
                      (st_r.hit[i] & ~clr_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '{prev: {W{1'b1}}, hit: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign latch_o = st_r.hit;

  edge_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.prev[0] && !pins_i[0]) |=> latch_o[0])
    else $error("Falling edge not captured.");

endmodule

//--- verification/mio_ext_pin.sv
// Model of the outside circuitry on one group of port pins.
`timescale 1ns/1ps
module mio_ext_pin #(
  parameter int W = 4
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] pu_i,
  input  wire logic [W-1:0] ext_en_i,
  input  wire logic [W-1:0] ext_val_i,
  output logic [W-1:0]      pin_o
);
  logic [W-1:0] flt_r = '0;

  // A line that nobody drives must not look stable, so it wanders.
  always_ff @(posedge clk_i) begin
    flt_r <= ~flt_r;
  end

  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe_i[i])
        pin_o[i] = 1'b0;
      else if (ext_en_i[i])
        pin_o[i] = ext_val_i[i];
      else if (pu_i[i])
        pin_o[i] = 1'b1;
      else
        pin_o[i] = flt_r[i];
    end
  end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the microcontroller I/O port block.
`timescale 1ns/1ps
module testbench;
  import mio_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  mio_cmd_s    cmd = '0;
  mio_rsp_s    rsp, rsp2;
  logic [3:0]  inp = 4'hf, nib, pa_i, pa_o, pa_oe, ax_i, ax_o, ax_oe;
  logic [3:0]  pa_en = '0, ax_en = '0, pa_val = '0, ax_val = '0;
  logic [3:0]  qpu = 4'hf, pa_oe2;
  logic [7:0]  ta_i, ta_o, ta_oe, ta_pu, tb_i, tb_o, tb_oe, tb_pu;
  logic [7:0]  ta_en = '0, ta_val = '0, tb_en = '0, tb_val = '0, b, m;
  logic        osc = 1'b1, hw = 1'b0, si = 1'b1, so, sk, a;
  logic [31:0] rnd = 32'h4cd7a801;
  int          err_count = 0, total_checks = 0, exp_nib = 0;

  always #12.5 clk = ~clk;

  mio_ports u_dut (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .CMD_I(cmd), .RSP_O(rsp),
    .IN_PINS_I(inp), .OSC_PIN_I(osc), .OUT_NIBBLE_O(nib),
    .PORTA_I(pa_i), .PORTA_O(pa_o), .PORTA_OE_O(pa_oe),
    .AUX_I(ax_i), .AUX_O(ax_o), .AUX_OE_O(ax_oe),
    .TRIA_I(ta_i), .TRIA_O(ta_o), .TRIA_OE_O(ta_oe), .TRIA_PU_O(ta_pu),
    .HOST_WR_I(hw), .TRIB_I(tb_i), .TRIB_O(tb_o), .TRIB_OE_O(tb_oe),
    .TRIB_PU_O(tb_pu), .SER_IN_I(si), .SER_OUT_O(so), .SER_CLK_O(sk));

  // Reduced-pin variant without oscillator input shares all stimulus.
  mio_ports #(.PORTA_PINS(2), .OSC_INPUT(1'b0)) u_dut2 (
    .REF_CLK_I(clk), .SYS_RST_I(rst), .CMD_I(cmd), .RSP_O(rsp2),
    .IN_PINS_I(inp), .OSC_PIN_I(osc), .OUT_NIBBLE_O(),
    .PORTA_I(pa_i), .PORTA_O(), .PORTA_OE_O(pa_oe2),
    .AUX_I(ax_i), .AUX_O(), .AUX_OE_O(),
    .TRIA_I(ta_i), .TRIA_O(), .TRIA_OE_O(), .TRIA_PU_O(),
    .HOST_WR_I(hw), .TRIB_I(tb_i), .TRIB_O(), .TRIB_OE_O(),
    .TRIB_PU_O(), .SER_IN_I(si), .SER_OUT_O(), .SER_CLK_O());

  mio_ext_pin u_pa (.clk_i(clk), .oe_i(pa_oe), .pu_i(qpu),
    .ext_en_i(pa_en), .ext_val_i(pa_val), .pin_o(pa_i));
  mio_ext_pin u_ax (.clk_i(clk), .oe_i(ax_oe), .pu_i(qpu),
    .ext_en_i(ax_en), .ext_val_i(ax_val), .pin_o(ax_i));
  mio_ext_pin #(.W(8)) u_ta (.clk_i(clk), .oe_i(ta_oe), .pu_i(ta_pu),
    .ext_en_i(ta_en), .ext_val_i(ta_val), .pin_o(ta_i));
  mio_ext_pin #(.W(8)) u_tb (.clk_i(clk), .oe_i(tb_oe), .pu_i(tb_pu),
    .ext_en_i(tb_en), .ext_val_i(tb_val), .pin_o(tb_i));

  function automatic logic [31:0] step(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk_pin(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t pin got %h want %h", $time, got, exp);
    end
  endtask

  // A zero mask means only the skip flag is of interest.
  task automatic chk_rsp(logic [7:0] msk, logic [7:0] exp, logic skp);
    total_checks++;
    if (rsp.valid !== 1'b1 || (msk == 8'h00 ? rsp.skip !== skp :
        (rsp.data & msk) !== exp)) begin
      err_count++;
      $display("BAD %0t answer %h skip %b want %h", $time, rsp.data,
               rsp.skip, exp);
    end
  endtask

  task automatic run(mio_op_e o, logic [7:0] d, logic c = 1'b0);
    @(posedge clk);
    cmd <= '{o, d, rnd[3:0], c};
    @(posedge clk);
    cmd.op <= OP_NONE;
    #1;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    $display("BAD %0t run did not finish in time", $time);
    err_count++;
    results();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk_pin({nib, pa_oe}, 8'h00);
    chk_pin({so, sk, 6'h00} | ta_pu | ta_oe, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rnd = step(rnd);
      run(OP_OUT_PTR_NIBBLE, ~{rnd[3:0], rnd[3:0]});
      exp_nib = rnd[3:0];
      chk_pin({4'h0, nib}, 8'(exp_nib));
    end
    @(posedge clk);
    inp <= 4'h5;
    @(posedge clk);
    run(OP_READ_INPUT_LATCHES, 8'h00);
    chk_rsp(8'h1f, 8'h1a, 1'b0);
    chk_pin(rsp2.data, 8'h0a);
    osc <= 1'b0;
    run(OP_READ_INPUT_LATCHES, 8'h00);
    chk_rsp(8'h1f, 8'h00, 1'b0);
    run(OP_READ_INPUT_PORT, 8'h00);
    chk_rsp(8'h0f, 8'h05, 1'b0);
    for (int k = 0; k < 4; k++) begin
      rnd = step(rnd);
      b = (k == 3) ? 8'h00 : {4'h0, rnd[3:0]};
      m = {4'h0, rnd[7:4]};
      pa_en <= m[3:0];
      ax_en <= m[3:0];
      run(k[0] ? OP_OUT_MEM_PORT_A : OP_OUT_PORT_A_IMM, b);
      chk_pin({4'h0, pa_oe}, {4'h0, ~b[3:0]});
      run(OP_OUT_MEM_AUX, b);
      chk_pin({pa_o, ax_oe}, {b[3:0], ~b[3:0]});
      chk_pin({pa_oe2, ax_o}, {2'b00, ~b[1:0], b[3:0]});
      run(OP_READ_AUX_PORT, 8'h00);
      chk_rsp(8'h0f, b & ~m, 1'b0);
      run(OP_READ_PORT_A, 8'h00);
      chk_rsp(8'h0f, b & ~m, 1'b0);
      chk_pin(rsp2.data, {4'h0, b[3:2], b[1:0] & ~m[1:0]});
      run(OP_TEST_A_BIT, 8'(k));
      chk_rsp(8'h00, 8'h00, ~b[k] | m[k]);
      run(OP_TEST_A_GROUP, 8'h00);
      chk_rsp(8'h00, 8'h00, (b[3:0] & ~m[3:0]) == 4'h0);
    end
    ta_en <= 8'hff;
    ta_val <= 8'h3c;
    run(OP_READ_TRI_A, 8'h00);
    chk_rsp(8'hff, 8'h3c, 1'b0);
    chk_pin(ta_oe | ta_pu, 8'h00);
    rnd = step(rnd);
    b = rnd[7:0];
    m = rnd[15:8];
    ta_en <= m;
    ta_val <= 8'h00;
    run(OP_COPY_BUFFER, b);
    chk_pin(ta_o, b);
    run(OP_LOAD_ENABLE_IMM, 8'h04);
    chk_pin(ta_pu, b);
    chk_pin(ta_oe, ~b);
    run(OP_READ_TRI_A, 8'h00);
    chk_rsp(8'hff, b & ~m, 1'b0);
    @(posedge clk);
    hw <= 1'b1;
    @(posedge clk);
    hw <= 1'b0;
    run(OP_READ_BUFFER, 8'h00);
    chk_rsp(8'hff, b, 1'b0);
    run(OP_TABLE_LOAD_BUFFER, ~b);
    chk_pin(ta_pu, ~b);
    run(OP_COPY_TO_ENABLE, 8'h00);
    chk_pin(ta_pu | ta_oe, 8'h00);
    rnd = step(rnd);
    b = rnd[7:0];
    run(OP_COPY_BUS_B, b);
    chk_pin(tb_o, b);
    run(OP_LOAD_ENABLE_IMM, 8'h0f);
    chk_pin(tb_pu | tb_oe, 8'h00);
    run(OP_COPY_TO_ENABLE, 8'h40);
    chk_pin(tb_pu, b);
    tb_en <= 8'hff;
    run(OP_READ_TRI_B, 8'h00);
    chk_rsp(8'hff, 8'h00, 1'b0);
    tb_en <= 8'h00;
    run(OP_READ_TRI_B, 8'h00);
    chk_rsp(8'hff, b, 1'b0);
    run(OP_SWAP_ACC_SHIFT, 8'h0f, 1'b1);
    chk_pin({7'h0, sk}, 8'h01);
    run(OP_LOAD_ENABLE_IMM, 8'h08);
    chk_pin({7'h0, so}, 8'h01);
    si <= 1'b0;
    @(posedge clk);
    si <= 1'b1;
    run(OP_SWAP_ACC_SHIFT, 8'h03, 1'b0);
    chk_rsp(8'h0f, 8'h0e, 1'b0);
    chk_pin({7'h0, sk}, 8'h00);
    run(OP_SWAP_ACC_SHIFT, 8'h00, 1'b1);
    chk_rsp(8'h0f, 8'h03, 1'b0);
    run(OP_LOAD_ENABLE_IMM, 8'h09);
    a = sk;
    @(posedge clk);
    #1;
    chk_pin({7'h0, sk}, {7'h0, ~a});
    repeat (5) @(posedge clk);
    #1;
    chk_pin({7'h0, so}, 8'h01);
    run(OP_SWAP_ACC_SHIFT, 8'h00, 1'b1);
    chk_rsp(8'h0f, 8'h0f, 1'b0);
    @(posedge clk);
    si <= 1'b0;
    repeat (5) @(posedge clk);
    run(OP_SWAP_ACC_SHIFT, 8'h00, 1'b1);
    chk_rsp(8'h0f, 8'h00, 1'b0);
    run(OP_LOAD_ENABLE_IMM, 8'h08);
    chk_pin({7'h0, sk}, 8'h01);
    @(posedge clk);
    #1;
    chk_pin({7'h0, sk}, 8'h01);
    chk_pin({4'h0, nib}, 8'(exp_nib));
    results();
  end
endmodule
